// ===== scsi_recovery_pkg.sv
// constants for the error-recovery command interpreter
package scsi_recovery_pkg;
    // command table
    localparam int NSLOT = 8;
    localparam int NBUSY = 7;
    localparam int WQ_RECOVERY = 0;
    // command codes
    localparam logic [7:0] CMD_BUS_INQ = 8'h45;
    localparam logic [7:0] CMD_CMD_INQ = 8'h46;
    localparam logic [7:0] CMD_CANCEL = 8'h48;
    // error codes
    localparam logic [7:0] ERR_BAD_TYPE = 8'hc0;
    localparam logic [7:0] ERR_TIMEOUT = 8'hc1;
    localparam logic [7:0] ERR_NO_BLOCK = 8'h82;
    localparam logic [7:0] ERR_EXCESS = 8'h83;
    localparam logic [7:0] ERR_DIRECTION = 8'h84;
    // command state codes, also the stored slot state
    localparam logic [7:0] CS_NOT_FOUND = 8'h01;
    localparam logic [2:0] CS_QUEUED = 3'h2;
    localparam logic [2:0] CS_ACTIVE = 3'h3;
    localparam logic [2:0] CS_DISCONNECTED = 3'h4;
    localparam logic [2:0] CS_DONE = 3'h5;
    localparam logic [2:0] CS_CMD_QUEUE = 3'h6;
    // response status word bits
    localparam int CRSW_CRBV = 0;
    localparam int CRSW_ER = 2;
    localparam int CRSW_SC = 7;
    localparam logic [15:0] CRSW_OK = 16'h0001;
    localparam logic [15:0] CRSW_FAIL = 16'h0005;
    localparam logic [15:0] CRSW_CTRL_ERR = 16'h0085;
    // event kinds from the bus sequencer
    localparam logic [2:0] EV_BAD_TYPE = 3'h0;
    localparam logic [2:0] EV_TIMEOUT = 3'h1;
    localparam logic [2:0] EV_RECONNECT = 3'h2;
    localparam logic [2:0] EV_EXCESS = 3'h3;
    localparam logic [2:0] EV_DIRECTION = 3'h4;
    localparam logic [2:0] EV_BIT_CMD = 3'h5;
    // command register fields
    localparam int CMDF_CODE_LSB = 0;
    localparam int CMDF_PORT = 8;
    localparam int CMDF_WQ_LSB = 9;
    // register offsets
    localparam logic [7:0] REG_COMMAND = 8'h00;
    localparam logic [7:0] REG_TAG = 8'h04;
    localparam logic [7:0] REG_CRSW = 8'h08;
    localparam logic [7:0] REG_CODE = 8'h0c;
    localparam logic [7:0] REG_INFO = 8'h10;
    localparam logic [7:0] REG_ACTIVE_TAG = 8'h14;
    localparam logic [7:0] REG_BUSY_BASE = 8'h18;
    localparam logic [7:0] REG_ENGINE = 8'h34;
    localparam logic [7:0] REG_CQE_TAG = 8'h38;
    // interpreter states, gray along idle, scan, post
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_POST = 2'b11
    } fsm_e;
endpackage : scsi_recovery_pkg

// ===== scsi_error_recovery_commands.sv
// error-recovery command interpreter with controller error reporting
`timescale 1ns/1ps
`default_nettype none
// Contract
// - bit-type command completions go out on the error vector
// - five listed error conditions use the error vector
// - listed error responses set status word bit 7
// - listed errors return a status block, bit commands do not
// - invalid block type reports c0, timeout reports c1
// - no-block reconnect 82, excess data 83, direction mismatch 84
// - bus inquiry 45 returns active tag and disconnected tags
// - bus inquiry halts internal operation for a consistent snapshot
// - bus inquiry reports only the port the host selected
// - active tag is the command executing on the bus now
// - up to seven disconnected tags per port, in order
// - command inquiry 46 looks up the given tag, returns state
// - command inquiry suspends operation until status is posted
// - state codes 01 to 06 as defined
// - last operation and phase returned only when state is active
// - last operation codes 00 to 07 as defined
// - phase byte REQ bit7 down to I/O bit0, active high
// - cancel 48 stops the held command with the given tag
// - later reconnect of cancelled command raises no-block error
// - cancel with no match returns with error status
// - only the first matching block is cancelled; host keeps tags unique
// - defined controller errors give status word 0085
module scsi_error_recovery_commands (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdata,
    // command table loading from the sequencer
    input wire logic slotWe,
    input wire logic [2:0] slotIdx,
    input wire logic slotValidIn,
    input wire logic [31:0] slotTagIn,
    input wire logic [2:0] slotStateIn,
    input wire logic slotPortIn,
    // error and completion events
    input wire logic evValid,
    input wire logic [2:0] evKind,
    input wire logic [31:0] evTag,
    output logic evReady,
    // live controller state per port
    input wire logic [7:0] lastOpPri,
    input wire logic [7:0] lastOpSec,
    input wire logic [7:0] phasePri,
    input wire logic [7:0] phaseSec,
    // status
    output logic haltOps,
    output logic respPending,
    output logic errorVector
);
    scsi_recovery_pkg::fsm_e fsm, next_fsm;
    logic slotValid [scsi_recovery_pkg::NSLOT];
    logic [31:0] slotTag [scsi_recovery_pkg::NSLOT];
    logic [2:0] slotState [scsi_recovery_pkg::NSLOT];
    logic slotPort [scsi_recovery_pkg::NSLOT];
    logic [7:0] cmdCode;
    logic cmdPort;
    logic [3:0] cmdWq;
    logic [31:0] cmdTag;
    logic [2:0] scanIdx;
    logic found;
    logic [2:0] foundIdx;
    logic [15:0] crsw;
    logic [7:0] respCode;
    logic [7:0] respOp;
    logic [7:0] respPhase;
    logic [31:0] respTag;
    logic [31:0] activeTag;
    logic [31:0] busyTag [scsi_recovery_pkg::NBUSY];
    logic [2:0] busyCnt;

    // error code of an event kind
    function automatic logic [7:0] errCodeOf(input logic [2:0] kind);
        case (kind)
            scsi_recovery_pkg::EV_BAD_TYPE: errCodeOf = scsi_recovery_pkg::ERR_BAD_TYPE;
            scsi_recovery_pkg::EV_TIMEOUT: errCodeOf = scsi_recovery_pkg::ERR_TIMEOUT;
            scsi_recovery_pkg::EV_RECONNECT: errCodeOf = scsi_recovery_pkg::ERR_NO_BLOCK;
            scsi_recovery_pkg::EV_EXCESS: errCodeOf = scsi_recovery_pkg::ERR_EXCESS;
            scsi_recovery_pkg::EV_DIRECTION: errCodeOf = scsi_recovery_pkg::ERR_DIRECTION;
            default: errCodeOf = 8'h00;
        endcase
    endfunction : errCodeOf

    // busy tag word index from a byte address
    function automatic logic [2:0] busyIndexOf(input logic [7:0] a);
        logic [7:0] d;
        d = a - scsi_recovery_pkg::REG_BUSY_BASE;
        busyIndexOf = d[4:2];
    endfunction : busyIndexOf

    // disconnected slots that a reconnecting target may resume
    logic [scsi_recovery_pkg::NSLOT-1:0] reconHitVec;
    genvar g;
    generate
        for (g = 0; g < scsi_recovery_pkg::NSLOT; g++) begin : g_recon
            assign reconHitVec[g] = slotValid[g] && slotTag[g] == evTag
                && slotState[g] == scsi_recovery_pkg::CS_DISCONNECTED;
        end
    endgenerate

    // event and launch decode
    wire logic reconHit = |reconHitVec;
    wire logic evTake = evValid && evReady;
    wire logic evIsRecon = evKind == scsi_recovery_pkg::EV_RECONNECT;
    wire logic evIsBit = evKind == scsi_recovery_pkg::EV_BIT_CMD;
    wire logic evKnown = evKind <= scsi_recovery_pkg::EV_BIT_CMD;
    wire logic evPost = evTake && evKnown && !(evIsRecon && reconHit);
    wire logic evErr = evPost && !evIsBit;
    wire logic evCqeValid = evKind == scsi_recovery_pkg::EV_TIMEOUT
        || evKind == scsi_recovery_pkg::EV_EXCESS || evKind == scsi_recovery_pkg::EV_DIRECTION;
    wire logic cmdWrite = wrStb && addr == scsi_recovery_pkg::REG_COMMAND;
    wire logic launch = cmdWrite && fsm == scsi_recovery_pkg::ST_IDLE && !respPending && !evTake;
    wire logic crswWrite = wrStb && addr == scsi_recovery_pkg::REG_CRSW;
    wire logic [7:0] wrCode = wdata[scsi_recovery_pkg::CMDF_CODE_LSB +: 8];
    wire logic [3:0] wrWq = wdata[scsi_recovery_pkg::CMDF_WQ_LSB +: 4];

    // current scanned slot
    wire logic curValid = slotValid[scanIdx];
    wire logic [31:0] curTag = slotTag[scanIdx];
    wire logic [2:0] curState = slotState[scanIdx];
    wire logic curOnPort = curValid && slotPort[scanIdx] == cmdPort;
    wire logic scanLast = scanIdx == 3'(scsi_recovery_pkg::NSLOT - 1);
    wire logic isBusInq = cmdCode == scsi_recovery_pkg::CMD_BUS_INQ;
    wire logic isCmdInq = cmdCode == scsi_recovery_pkg::CMD_CMD_INQ;
    wire logic isCancel = cmdCode == scsi_recovery_pkg::CMD_CANCEL;
    wire logic curMatch = curValid && curTag == cmdTag && !found;
    wire logic inWq0 = cmdWq == 4'(scsi_recovery_pkg::WQ_RECOVERY);
    wire logic cmdLegal = inWq0 && (isBusInq || isCmdInq || isCancel);
    wire logic scanning = fsm == scsi_recovery_pkg::ST_SCAN;
    wire logic posting = fsm == scsi_recovery_pkg::ST_POST;
    wire logic cancelHit = posting && cmdLegal && isCancel && found;

    // state found for the inquiry, and the live bus view of its port
    wire logic [2:0] foundState = slotState[foundIdx];
    wire logic foundActive = found && foundState == scsi_recovery_pkg::CS_ACTIVE;
    wire logic foundPort = slotPort[foundIdx];
    wire logic [7:0] liveOp = foundPort ? lastOpSec : lastOpPri;
    wire logic [7:0] livePhase = foundPort ? phaseSec : phasePri;

    // state sequencing: one slot per cycle, then a post cycle
    always_comb begin
        next_fsm = fsm;
        case (fsm)
            scsi_recovery_pkg::ST_IDLE: if (launch) next_fsm = scsi_recovery_pkg::ST_SCAN;
            scsi_recovery_pkg::ST_SCAN: if (scanLast) next_fsm = scsi_recovery_pkg::ST_POST;
            scsi_recovery_pkg::ST_POST: next_fsm = scsi_recovery_pkg::ST_IDLE;
            default: next_fsm = scsi_recovery_pkg::ST_IDLE;
        endcase
    end

    // pending flag: a fresh response wins over the software acknowledge
    wire logic postSet = posting || evPost;
    wire logic next_pending = postSet || (respPending && !crswWrite);

    // halt while scanning, so the table cannot move under the snapshot
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fsm <= scsi_recovery_pkg::ST_IDLE;
            haltOps <= 1'b0;
            respPending <= 1'b0;
            evReady <= 1'b0;
        end else begin
            fsm <= next_fsm;
            haltOps <= next_fsm != scsi_recovery_pkg::ST_IDLE;
            respPending <= next_pending;
            evReady <= next_fsm == scsi_recovery_pkg::ST_IDLE && !next_pending;
        end
    end

    // command latch from the register port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdCode <= 8'h00;
            cmdPort <= 1'b0;
            cmdWq <= 4'h0;
            cmdTag <= 32'h0;
        end else begin
            if (launch) begin
                cmdCode <= wrCode;
                cmdPort <= wdata[scsi_recovery_pkg::CMDF_PORT];
                cmdWq <= wrWq;
            end
            if (wrStb && addr == scsi_recovery_pkg::REG_TAG && fsm == scsi_recovery_pkg::ST_IDLE) begin
                cmdTag <= wdata;
            end
        end
    end

    // command table; sequencer writes are dropped while halted
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < scsi_recovery_pkg::NSLOT; i++) begin
                slotValid[i] <= 1'b0;
                slotTag[i] <= 32'h0;
                slotState[i] <= 3'h0;
                slotPort[i] <= 1'b0;
            end
        end else begin
            if (slotWe && !haltOps) begin
                slotValid[slotIdx] <= slotValidIn;
                slotTag[slotIdx] <= slotTagIn;
                slotState[slotIdx] <= slotStateIn;
                slotPort[slotIdx] <= slotPortIn;
            end
            if (cancelHit) begin
                slotValid[foundIdx] <= 1'b0;
            end
        end
    end

    // scan: first tag match, and the bus picture of the selected port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scanIdx <= 3'h0;
            found <= 1'b0;
            foundIdx <= 3'h0;
            busyCnt <= 3'h0;
            activeTag <= 32'h0;
            for (int i = 0; i < scsi_recovery_pkg::NBUSY; i++) begin
                busyTag[i] <= 32'h0;
            end
        end else if (launch) begin
            scanIdx <= 3'h0;
            found <= 1'b0;
            busyCnt <= 3'h0;
            activeTag <= 32'h0;
            for (int i = 0; i < scsi_recovery_pkg::NBUSY; i++) begin
                busyTag[i] <= 32'h0;
            end
        end else if (scanning) begin
            scanIdx <= scanIdx + 3'h1;
            if (curMatch) begin
                found <= 1'b1;
                foundIdx <= scanIdx;
            end
            if (isBusInq && curOnPort && curState == scsi_recovery_pkg::CS_ACTIVE) begin
                activeTag <= curTag;
            end
            if (isBusInq && curOnPort && curState == scsi_recovery_pkg::CS_DISCONNECTED
                && busyCnt < 3'(scsi_recovery_pkg::NBUSY)) begin
                busyTag[busyCnt] <= curTag;
                busyCnt <= busyCnt + 3'h1;
            end
        end
    end

    // response block; bad type and reconnect errors carry no command block
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crsw <= 16'h0;
            respCode <= 8'h00;
            respOp <= 8'h00;
            respPhase <= 8'h00;
            respTag <= 32'h0;
            errorVector <= 1'b0;
        end else if (evPost) begin
            errorVector <= 1'b1;
            crsw <= evIsBit ? scsi_recovery_pkg::CRSW_OK : scsi_recovery_pkg::CRSW_CTRL_ERR;
            respCode <= errCodeOf(evKind);
            respTag <= evCqeValid ? evTag : 32'h0;
            respOp <= 8'h00;
            respPhase <= 8'h00;
        end else if (posting) begin
            errorVector <= 1'b0;
            respTag <= cmdTag;
            respOp <= 8'h00;
            respPhase <= 8'h00;
            respCode <= 8'h00;
            crsw <= scsi_recovery_pkg::CRSW_OK;
            if (!cmdLegal || (isCancel && !found)) begin
                crsw <= scsi_recovery_pkg::CRSW_FAIL;
            end else if (isCmdInq) begin
                respCode <= found ? 8'(foundState) : scsi_recovery_pkg::CS_NOT_FOUND;
                if (foundActive) begin
                    respOp <= liveOp;
                    respPhase <= livePhase;
                end
            end
        end
    end

    // read selection
    wire logic busyHit = addr >= scsi_recovery_pkg::REG_BUSY_BASE && addr < scsi_recovery_pkg::REG_ENGINE
        && addr[1:0] == 2'b00;
    wire logic [31:0] engineWord = {27'h0, found, busyCnt == 3'(scsi_recovery_pkg::NBUSY),
        errorVector, respPending, haltOps};
    wire logic [31:0] readWord =
        addr == scsi_recovery_pkg::REG_COMMAND ? {19'h0, cmdWq, cmdPort, cmdCode} :
        addr == scsi_recovery_pkg::REG_TAG ? cmdTag :
        addr == scsi_recovery_pkg::REG_CRSW ? {16'h0, crsw} :
        addr == scsi_recovery_pkg::REG_CODE ? {24'h0, respCode} :
        addr == scsi_recovery_pkg::REG_INFO ? {16'h0, respOp, respPhase} :
        addr == scsi_recovery_pkg::REG_ACTIVE_TAG ? activeTag :
        busyHit ? busyTag[busyIndexOf(addr)] :
        addr == scsi_recovery_pkg::REG_ENGINE ? engineWord :
        addr == scsi_recovery_pkg::REG_CQE_TAG ? respTag : 32'h0;

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rdStb ? readWord : 32'h0;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_bit_cmd;
        evPost && evIsBit |=> errorVector && crsw == scsi_recovery_pkg::CRSW_OK && respCode == 8'h00;
    endproperty
    a_bit_cmd: assert property (p_bit_cmd) else $error("bit command completion wrong");

    property p_err_vector;
        evErr |=> errorVector && respPending && respTag == ($past(evCqeValid) ? $past(evTag) : 32'h0);
    endproperty
    a_err_vector: assert property (p_err_vector) else $error("error not on error vector");

    property p_sc_bit;
        respPending && crsw[scsi_recovery_pkg::CRSW_SC] |-> errorVector && respCode[7];
    endproperty
    a_sc_bit: assert property (p_sc_bit) else $error("status change bit without error");

    property p_crsw_err;
        evErr |=> crsw == 16'h0085;
    endproperty
    a_crsw_err: assert property (p_crsw_err) else $error("controller error status word wrong");

    property p_timeout_code;
        evTake && evKind == scsi_recovery_pkg::EV_TIMEOUT |=> respCode == 8'hc1;
    endproperty
    a_timeout_code: assert property (p_timeout_code) else $error("timeout code wrong");

    property p_excess_code;
        evTake && evKind == scsi_recovery_pkg::EV_EXCESS |=> respCode == 8'h83;
    endproperty
    a_excess_code: assert property (p_excess_code) else $error("excess data code wrong");

    property p_recon_code;
        evTake && evIsRecon && !reconHit |=> respCode == 8'h82 && respTag == 32'h0;
    endproperty
    a_recon_code: assert property (p_recon_code) else $error("unknown reconnect not flagged");

    property p_halt;
        launch |=> haltOps [*8] ##1 haltOps ##1 (!haltOps && respPending);
    endproperty
    a_halt: assert property (p_halt) else $error("halt window wrong");

    property p_no_table_move;
        haltOps && !cancelHit |=> $stable(slotValid[slotIdx]);
    endproperty
    a_no_table_move: assert property (p_no_table_move) else $error("table moved during halt");

    property p_cancel_miss;
        posting && cmdLegal && isCancel && !found |=> crsw == 16'h0005 && !errorVector;
    endproperty
    a_cancel_miss: assert property (p_cancel_miss) else $error("cancel miss not failed");

    property p_info_gate;
        posting && isCmdInq && !foundActive |=> respOp == 8'h00 && respPhase == 8'h00;
    endproperty
    a_info_gate: assert property (p_info_gate) else $error("info returned while not active");

    // the list only grows on a disconnected slot of the selected port, and never past full
    property p_busy_limit;
        scanning && (busyCnt == 3'(scsi_recovery_pkg::NBUSY) || !(isBusInq && curOnPort
            && curState == scsi_recovery_pkg::CS_DISCONNECTED)) |=> $stable(busyCnt);
    endproperty
    a_busy_limit: assert property (p_busy_limit) else $error("busy tag list grew wrongly");

    c_bus_inq: cover property (posting && isBusInq && busyCnt > 3'h0);
    c_cmd_active: cover property (posting && isCmdInq && foundActive);
    c_cancel_hit: cover property (cancelHit);
    c_ctrl_err: cover property (evErr ##1 crswWrite);
endmodule : scsi_error_recovery_commands
`default_nettype wire

// ===== seq_model.sv
// sequencer model: command table loads and error events
`timescale 1ns/1ps
`default_nettype none
module seq_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // table loading
    output logic slotWe,
    output logic [2:0] slotIdx,
    output logic slotValidIn,
    output logic [31:0] slotTagIn,
    output logic [2:0] slotStateIn,
    output logic slotPortIn,
    // events and interpreter status
    output logic evValid,
    output logic [2:0] evKind,
    output logic [31:0] evTag,
    input wire logic evReady,
    input wire logic haltOps
);
    // quiet lines at time zero
    initial begin
        {slotWe, slotIdx, slotValidIn, slotStateIn, slotPortIn} = '0;
        {evValid, evKind} = '0;
        slotTagIn = 32'h0;
        evTag = 32'h0;
    end
    // one table write, held back while a snapshot is being taken
    task automatic load(input logic [2:0] i, input logic v, input logic [31:0] t,
                        input logic [2:0] s, input logic p);
        do @(posedge ref_clk); while (haltOps || !rst_n);
        {slotWe, slotIdx, slotValidIn, slotTagIn, slotStateIn, slotPortIn} <= {1'b1, i, v, t, s, p};
        @(posedge ref_clk);
        slotWe <= 1'b0;
        slotTagIn <= ~t; // stale data must never look valid
    endtask : load
    // one event, held until the interpreter takes it
    task automatic post(input logic [2:0] k, input logic [31:0] t);
        @(posedge ref_clk);
        {evValid, evKind, evTag} <= {1'b1, k, t};
        do @(posedge ref_clk); while (!evReady);
        evValid <= 1'b0;
        evTag <= ~t;
    endtask : post
endmodule : seq_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for the error-recovery command interpreter
`timescale 1ns/1ps
`default_nettype none
`define R(x) scsi_recovery_pkg::x
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    // stimulus, observed outputs and the bench model of the table
    logic ref_clk = 0;
    logic rst_n = 0;
    logic wrStb = 0;
    logic rdStb = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0;
    logic [7:0] lastOpPri = 0, lastOpSec = 0, phasePri = 0, phaseSec = 0;
    logic [31:0] rdata, slotTagIn, evTag, mTag [8];
    logic [2:0] slotIdx, slotStateIn, evKind, mSt [8];
    logic slotWe, slotValidIn, slotPortIn, evValid, evReady, haltOps, respPending, errorVector;
    logic mPort [8], mVal [8];
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    scsi_error_recovery_commands scsi_error_recovery_commands_i (.ref_clk, .rst_n, .addr,
        .wdata, .wrStb, .rdStb, .rdata, .slotWe, .slotIdx, .slotValidIn, .slotTagIn,
        .slotStateIn, .slotPortIn, .evValid, .evKind, .evTag, .evReady, .lastOpPri,
        .lastOpSec, .phasePri, .phaseSec, .haltOps, .respPending, .errorVector);
    seq_model seq_model_i (.ref_clk, .rst_n, .slotWe, .slotIdx, .slotValidIn, .slotTagIn,
        .slotStateIn, .slotPortIn, .evValid, .evKind, .evTag, .evReady, .haltOps);
    always #20 ref_clk = ~ref_clk;
    // hang guard, far above the under one thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // register port cycles; read data is looked at in its one valid cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {wrStb, addr, wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        wrStb <= 1'b0;
        wdata <= ~d;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        {rdStb, addr} <= {1'b1, a};
        @(posedge ref_clk);
        rdStb <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rchk
    task automatic waitResp();
        for (int n = 0; n < 60 && respPending !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(respPending, 1'b1)
        `CHK(evReady, 1'b0)
    endtask : waitResp
    task automatic ack();
        wr(`R(REG_CRSW), 32'h0);
        @(posedge ref_clk);
        #1;
        `CHK(respPending, 1'b0)
        `CHK(evReady, 1'b1)
    endtask : ack
    function automatic int find(input logic [31:0] t);
        for (int i = 0; i < 8; i++) if (mVal[i] && mTag[i] === t) return i;
        return -1;
    endfunction : find
    // tag then command; a queue-0 command must freeze the engine at once
    task automatic cmd(input logic [7:0] c, input logic p, input logic [3:0] q,
                       input logic [31:0] t, input logic [15:0] s);
        wr(`R(REG_TAG), t);
        wr(`R(REG_COMMAND), {19'h0, q, p, c});
        @(posedge ref_clk);
        #1;
        if (q == 0) `CHK(haltOps, 1'b1)
        waitResp();
        `CHK(errorVector, 1'b0)
        rchk(`R(REG_CRSW), {16'h0, s});
    endtask : cmd
    task automatic busInq(input logic p);
        logic [31:0] act, busy [7];
        int n;
        act = 0;
        n = 0;
        busy = '{default: 32'h0};
        for (int i = 7; i >= 0; i--) if (mVal[i] && mPort[i] == p && mSt[i] == 3) act = mTag[i];
        for (int i = 0; i < 8; i++) begin
            if (mVal[i] && mPort[i] == p && mSt[i] == 4 && n < 7) begin
                busy[n] = mTag[i];
                n++;
            end
        end
        cmd(8'h45, p, 4'h0, 32'h0, 16'h0001);
        rchk(`R(REG_ACTIVE_TAG), act);
        for (int j = 0; j < 7; j++) rchk(`R(REG_BUSY_BASE) + 8'(4 * j), busy[j]);
        ack();
        $display("test bus inquiry port %0d done", p);
    endtask : busInq
    task automatic cmdInq(input logic [31:0] t);
        int i;
        i = find(t);
        cmd(8'h46, 1'b0, 4'h0, t, 16'h0001);
        rchk(`R(REG_CODE), i < 0 ? 32'h1 : {29'h0, mSt[i]});
        if (i >= 0 && mSt[i] == 3) rchk(`R(REG_INFO), mPort[i] ? {16'h0, lastOpSec, phaseSec}
            : {16'h0, lastOpPri, phasePri});
        else rchk(`R(REG_INFO), 32'h0);
        ack();
    endtask : cmdInq
    task automatic cancel(input logic [31:0] t);
        int i;
        i = find(t);
        cmd(8'h48, 1'b0, 4'h0, t, i < 0 ? 16'h0005 : 16'h0001);
        if (i >= 0) mVal[i] = 0;
        ack();
    endtask : cancel
    task automatic ev(input logic [2:0] k, input logic [31:0] t, input logic [7:0] c);
        seq_model_i.post(k, t);
        waitResp();
        `CHK(errorVector, 1'b1)
        rchk(`R(REG_CRSW), k == 5 ? 32'h1 : 32'h85);
        rchk(`R(REG_CODE), {24'h0, c});
        rchk(`R(REG_CQE_TAG), k inside {1, 3, 4} ? t : 32'h0);
        ack();
    endtask : ev
    // main sequence
    initial begin
        logic [7:0] codes [6];
        logic [2:0] other [3];
        codes = '{8'hc0, 8'hc1, 8'h82, 8'h83, 8'h84, 8'h00};
        other = '{3'h2, 3'h5, 3'h6};
        void'($urandom(32'h363f99dd));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 6; k++) ev(3'(k), $urandom, codes[k]);
        $display("test controller errors done");
        // slots 0 and 1 on the bus, slot 3 disconnected, slot 7 empty
        for (int i = 0; i < 8; i++) begin
            mTag[i] = $urandom & 32'hffff_fff0 | 32'(i);
            mSt[i] = i < 2 ? 3'h3 : (i == 3 || $urandom % 2) ? 3'h4 : other[$urandom % 3];
            mPort[i] = i < 2 ? i[0] : 1'($urandom);
            mVal[i] = i != 7;
            seq_model_i.load(3'(i), mVal[i], mTag[i], mSt[i], mPort[i]);
        end
        busInq(1'b0);
        busInq(1'b1);
        // every slot, an unknown tag, then all operation codes on slot 0
        for (int j = 0; j < 17; j++) begin
            @(posedge ref_clk);
            {lastOpPri, lastOpSec} <= {8'(j % 8), 8'(7 - j % 8)};
            {phasePri, phaseSec} <= {8'h01 << (j % 8), 8'h80 >> (j % 8)};
            cmdInq(j < 8 ? mTag[j] : j == 8 ? 32'h5a5a_000f : mTag[0]);
        end
        $display("test command inquiry done");
        // same tag held twice: only the lower slot goes
        {mTag[6], mSt[5], mSt[6], mVal[5], mVal[6]} = {mTag[5], 3'h2, 3'h6, 2'b11};
        seq_model_i.load(3'h5, 1'b1, mTag[5], 3'h2, mPort[5]);
        seq_model_i.load(3'h6, 1'b1, mTag[6], 3'h6, mPort[6]);
        cancel(mTag[5]);
        cmdInq(mTag[6]);
        cancel(mTag[3]);
        ev(3'h2, mTag[3], 8'h82);
        cancel(32'h5a5a_000f);
        cmd(8'h45, 1'b0, 4'h1, 32'h0, 16'h0005);
        ack();
        rchk(8'hfc, 32'h0);
        $display("test cancel and refusals done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
